//--- verilog/ivs_top.v
// interrupt flags, vector selection and stack pointer bookkeeping
// assumes the core pulses push/pull/entry strobes on clk_i; sources are pins
`include "ivs_defines.vh"
module ivs_top (
   input wire clk_i, // system clock, 10 MHz
   input wire rst_i, // synchronous reset, high
   input wire ce_i, // clock enable, freezes all state low
   input wire [15:0] wb_adr_i, // wishbone address
   input wire [31:0] wb_dat_i, // wishbone write data
   input wire [3:0] wb_sel_i, // wishbone byte selects
   input wire wb_we_i, // wishbone write
   input wire wb_cyc_i, // wishbone cycle
   input wire wb_stb_i, // wishbone strobe
   output reg [31:0] wb_dat_o, // wishbone read data
   output reg wb_ack_o, // wishbone acknowledge
   input wire timer_overflow_i, // timer overflow request level
   input wire timer_ch0_i, // timer channel 0 request level
   input wire timer_ch1_i, // timer channel 1 request level
   input wire ext_request_i, // external request level
   input wire keypad_i, // keyboard request level
   input wire conversion_done_i, // adc done request level
   input wire software_trap_i, // core executes a software trap, pulse
   input wire irq_entry_i, // core begins interrupt entry, pulse
   input wire call_i, // core begins subroutine call, pulse
   input wire push_i, // single push, pulse
   input wire pull_i, // single pull, pulse
   input wire [15:0] fetch_adr_i, // core vector fetch address
   output reg [7:0] fetch_dat_o, // vector byte for fetch_adr_i
   output reg [15:0] vector_o, // selected vector high byte address
   output reg irq_pending_o, // some enabled source pending
   output reg [15:0] sp_o, // stack pointer
   output reg [2:0] stack_left_o, // bytes still to push for entry or call
   output reg ram_hit_o, // fetch_adr_i lies in ram
   output reg irq_o // interrupt to core, level
);
   // ----------------------------------------
   // synchronisers for source pins
   // ----------------------------------------
   reg [5:0] src_m_r;
   reg [5:0] src_s_r;
   // two stages; only the second stage feeds logic
   always @(posedge clk_i) begin
      if (rst_i) begin
         src_m_r <= 6'h0;
         src_s_r <= 6'h0;
      end else if (ce_i) begin
         src_m_r <= {conversion_done_i, keypad_i, ext_request_i,
                     timer_ch0_i, timer_ch1_i, timer_overflow_i};
         src_s_r <= src_m_r;
      end
   end
   wire timer_overflow_flag = src_s_r[0];
   wire timer_ch1_flag = src_s_r[1];
   wire timer_ch0_flag = src_s_r[2];
   wire ext_request_flag = src_s_r[3];
   wire keypad_flag = src_s_r[4];
   wire conversion_done_flag = src_s_r[5];

   // ----------------------------------------
   // source flag registers
   // ----------------------------------------
   reg [7:0] flags_one_r;
   reg [7:0] flags_three_r;
   reg [7:0] flags_two_r;
   // read-only mirrors of the requests; writes never touch them
   always @(posedge clk_i) begin
      if (rst_i) begin
         flags_one_r <= `IVS_RESET_BYTE;
         flags_two_r <= `IVS_RESET_BYTE;
         flags_three_r <= `IVS_RESET_BYTE;
      end else if (ce_i) begin
         flags_one_r <= 8'h00;
         flags_one_r[`IVS_BIT_OVF] <= timer_overflow_flag;
         flags_one_r[`IVS_BIT_CH1] <= timer_ch1_flag;
         flags_one_r[`IVS_BIT_CH0] <= timer_ch0_flag;
         flags_one_r[`IVS_BIT_EXT] <= ext_request_flag;
         flags_two_r <= 8'h00;
         flags_three_r <= {7'h00, conversion_done_flag};
      end
   end

   // ----------------------------------------
   // priority selection
   // ----------------------------------------
   reg [7:0] mask_r;
   reg [7:0] status_r;
   reg swi_r;
   reg [15:0] vec_nxt;
   reg any_nxt;
   wire [6:0] req = {swi_r, ext_request_flag & mask_r[7], timer_ch0_flag & mask_r[6],
                     timer_ch1_flag & mask_r[5], timer_overflow_flag & mask_r[4],
                     keypad_flag & mask_r[3], conversion_done_flag & mask_r[2]};
   // fixed order; lower sources keep their level and wait their turn
   always @* begin
      any_nxt = 1'b1;
      if (req[6]) vec_nxt = `IVS_VEC_SWI;
      else if (req[5]) vec_nxt = `IVS_VEC_EXT;
      else if (req[4]) vec_nxt = `IVS_VEC_CH0;
      else if (req[3]) vec_nxt = `IVS_VEC_CH1;
      else if (req[2]) vec_nxt = `IVS_VEC_OVF;
      else if (req[1]) vec_nxt = `IVS_VEC_KEY;
      else if (req[0]) vec_nxt = `IVS_VEC_ADC;
      else begin
         vec_nxt = `IVS_VEC_RST;
         any_nxt = 1'b0;
      end
   end

   // ----------------------------------------
   // vector table, two bytes per entry
   // ----------------------------------------
   reg [15:0] vec_table_r [0:7];
   reg [7:0] fetch_nxt;
   reg [2:0] tbl_slot;
   reg [2:0] wb_tbl;
   // table slots: 0 adc,1 key,2 ovf,3 ch1,4 ch0,5 ext,6 swi,7 reset
   always @* begin
      fetch_nxt = 8'h00;
      if (fetch_adr_i >= `IVS_VEC_ADC) begin
         if (fetch_adr_i[0]) fetch_nxt = vec_table_r[tbl_slot][7:0];
         else fetch_nxt = vec_table_r[tbl_slot][15:8];
      end
   end
   // address pair to slot; unused pairs fall onto the reset slot
   always @* begin
      case (fetch_adr_i[15:1])
         15'h7fef: tbl_slot = 3'd0;
         15'h7ff0: tbl_slot = 3'd1;
         15'h7ff9: tbl_slot = 3'd2;
         15'h7ffa: tbl_slot = 3'd3;
         15'h7ffb: tbl_slot = 3'd4;
         15'h7ffd: tbl_slot = 3'd5;
         15'h7ffe: tbl_slot = 3'd6;
         15'h7fff: tbl_slot = 3'd7;
         default: tbl_slot = 3'd7;
      endcase
   end

   // ----------------------------------------
   // stack pointer and entry sequencing
   // ----------------------------------------
   localparam ST_IDLE = 3'b001;
   localparam ST_IRQ = 3'b010;
   localparam ST_CALL = 3'b100;
   reg [2:0] state_r;
   reg [15:0] sp_r;
   reg [2:0] left_r;
   // entry counts five bytes (no index-high), call counts two
   always @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= ST_IDLE;
         sp_r <= `IVS_SP_RESET;
         left_r <= 3'd0;
      end else if (ce_i) begin
         if (push_i && !pull_i) sp_r <= sp_r - 16'h0001;
         else if (pull_i && !push_i) sp_r <= sp_r + 16'h0001;
         case (state_r)
            ST_IDLE: begin
               if (irq_entry_i) begin
                  state_r <= ST_IRQ;
                  left_r <= `IVS_IRQ_BYTES;
               end else if (call_i) begin
                  state_r <= ST_CALL;
                  left_r <= `IVS_CALL_BYTES;
               end
            end
            ST_IRQ, ST_CALL: begin
               if (push_i) begin
                  left_r <= left_r - 3'd1;
                  if (left_r == 3'd1) state_r <= ST_IDLE;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // interrupt status and mask
   // ----------------------------------------
   wire [7:0] ev = {ext_request_flag, timer_ch0_flag, timer_ch1_flag,
                    timer_overflow_flag, keypad_flag, conversion_done_flag, 2'b00};
   wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wr_lane = bus_req & wb_we_i & wb_sel_i[0];
   // set wins over a write-one clear in the same cycle
   always @(posedge clk_i) begin
      if (rst_i) begin
         status_r <= 8'h00;
         mask_r <= 8'h00;
         swi_r <= 1'b0;
      end else if (ce_i) begin
         status_r <= (status_r & ~((wr_lane && wb_adr_i == `IVS_ADDR_STATUS) ?
                     wb_dat_i[7:0] : 8'h00)) | ev;
         if (wr_lane && wb_adr_i == `IVS_ADDR_MASK) mask_r <= wb_dat_i[7:0];
         if (software_trap_i) swi_r <= 1'b1;
         else if (irq_entry_i && vec_nxt == `IVS_VEC_SWI) swi_r <= 1'b0;
      end
   end

   // ----------------------------------------
   // vector table writes and bus slave
   // ----------------------------------------
   reg [31:0] rd_nxt;
   wire ram_chk = (wb_adr_i >= `IVS_RAM_LO) && (wb_adr_i <= `IVS_RAM_HI);
   // unmapped addresses below ffde read zero (one inside 0080..00ff) and still ack; one wait-free cycle
   always @* begin
      case (wb_adr_i)
         `IVS_ADDR_FLAGS_ONE: rd_nxt = {24'h0, flags_one_r};
         `IVS_ADDR_FLAGS_TWO: rd_nxt = {24'h0, flags_two_r};
         `IVS_ADDR_FLAGS_THREE: rd_nxt = {24'h0, flags_three_r};
         `IVS_ADDR_STATUS: rd_nxt = {24'h0, status_r};
         `IVS_ADDR_MASK: rd_nxt = {24'h0, mask_r};
         `IVS_ADDR_SP: rd_nxt = {16'h0, sp_r};
         `IVS_ADDR_VEC: rd_nxt = {16'h0, vec_nxt};
         default: begin
            if (wb_adr_i >= `IVS_VEC_ADC) rd_nxt = {16'h0, vec_table_r[wb_tbl]};
            else rd_nxt = {31'h0, ram_chk};
         end
      endcase
   end
   // same slot map for the bus side
   always @* begin
      case (wb_adr_i[15:1])
         15'h7fef: wb_tbl = 3'd0;
         15'h7ff0: wb_tbl = 3'd1;
         15'h7ff9: wb_tbl = 3'd2;
         15'h7ffa: wb_tbl = 3'd3;
         15'h7ffb: wb_tbl = 3'd4;
         15'h7ffd: wb_tbl = 3'd5;
         15'h7ffe: wb_tbl = 3'd6;
         default: wb_tbl = 3'd7;
      endcase
   end
   integer i;
   // vector contents are written as a 16-bit word at the high-byte address
   always @(posedge clk_i) begin
      if (rst_i) begin
         for (i = 0; i < 8; i = i + 1) vec_table_r[i] <= 16'h0000;
      end else if (ce_i && bus_req && wb_we_i && wb_adr_i >= `IVS_VEC_ADC) begin
         if (wb_sel_i[0]) vec_table_r[wb_tbl][7:0] <= wb_dat_i[7:0];
         if (wb_sel_i[1]) vec_table_r[wb_tbl][15:8] <= wb_dat_i[15:8];
      end
   end

   // ----------------------------------------
   // registered outputs
   // ----------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         fetch_dat_o <= 8'h00;
         vector_o <= `IVS_VEC_RST;
         irq_pending_o <= 1'b0;
         sp_o <= `IVS_SP_RESET;
         stack_left_o <= 3'd0;
         ram_hit_o <= 1'b0;
         irq_o <= 1'b0;
      end else if (ce_i) begin
         wb_ack_o <= bus_req;
         wb_dat_o <= (bus_req && !wb_we_i) ? rd_nxt : 32'h0000_0000;
         fetch_dat_o <= fetch_nxt;
         vector_o <= vec_nxt;
         irq_pending_o <= any_nxt;
         sp_o <= sp_r;
         stack_left_o <= left_r;
         ram_hit_o <= (fetch_adr_i >= `IVS_RAM_LO) && (fetch_adr_i <= `IVS_RAM_HI);
         irq_o <= |(status_r & mask_r);
      end
   end
endmodule // ivs_top

//--- verilog/ivs_defines.vh
// constants for the interrupt vector and stack map block
// assumes a 10 MHz clk_i and a classic wishbone master on the register side
`ifndef IVS_DEFINES_VH
`define IVS_DEFINES_VH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define IVS_ADDR_FLAGS_ONE 16'hfe04
`define IVS_ADDR_FLAGS_TWO 16'hfe05
`define IVS_ADDR_FLAGS_THREE 16'hfe06
`define IVS_ADDR_STATUS 16'hfe10
`define IVS_ADDR_MASK 16'hfe11
`define IVS_ADDR_SP 16'hfe12
`define IVS_ADDR_VEC 16'hfe13
`define IVS_ADDR_RAM_CHK 16'hfe14
`define IVS_RESET_BYTE 8'h00
`define IVS_SP_RESET 16'h00ff
// ----------------------------------------
// field positions in irq_source_flags_one; IVS_BIT_ADC is bit 0 of flags_three_r
// ----------------------------------------
`define IVS_BIT_OVF 6
`define IVS_BIT_CH1 5
`define IVS_BIT_CH0 4
`define IVS_BIT_EXT 2
`define IVS_BIT_ADC 0
// ----------------------------------------
// vector addresses (high byte location)
// ----------------------------------------
`define IVS_VEC_ADC 16'hffde
`define IVS_VEC_KEY 16'hffe0
`define IVS_VEC_OVF 16'hfff2
`define IVS_VEC_CH1 16'hfff4
`define IVS_VEC_CH0 16'hfff6
`define IVS_VEC_EXT 16'hfffa
`define IVS_VEC_SWI 16'hfffc
`define IVS_VEC_RST 16'hfffe
// ----------------------------------------
// ram window and stacking depths
// ----------------------------------------
`define IVS_RAM_LO 16'h0080
`define IVS_RAM_HI 16'h00ff
`define IVS_IRQ_BYTES 3'd5
`define IVS_CALL_BYTES 3'd2
`endif

//--- testbench/ivs_top_asserts.sv
// checker: bus answer, flag register layout, stack bookkeeping and ram decode
// assumes one clock domain; bound to ivs_top at the foot of this file
module ivs_top_asserts (
   input wire clk_i, // clock
   input wire rst_i, // reset
   input wire [15:0] wb_adr_i, // address
   input wire wb_we_i, // write
   input wire wb_cyc_i, // cycle
   input wire wb_stb_i, // strobe
   input wire [31:0] wb_dat_o, // read data
   input wire wb_ack_o, // answer
   input wire push_i, // push
   input wire pull_i, // pull
   input wire irq_entry_i, // entry
   input wire call_i, // call
   input wire [15:0] fetch_adr_i, // fetch address
   input wire [15:0] sp_o, // stack pointer
   input wire [2:0] stack_left_o, // bytes left
   input wire ram_hit_o // ram decode
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // read answers only, writes carry no data back
   wire rd_ack = wb_ack_o && !wb_we_i;
   // ----------------------------------------
   // relations at the ports
   // ----------------------------------------
   bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not answered in the next cycle");
   ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("acknowledge held longer than one cycle");
   flags_one_zero_a: assert property (rd_ack && wb_adr_i == 16'hfe04 |-> (wb_dat_o[7:0] & 8'h8b) == 8'h00)
      else $error("unused bits of first flag register not zero");
   flags_two_zero_a: assert property (rd_ack && wb_adr_i == 16'hfe05 |-> wb_dat_o[6:0] == 7'h00)
      else $error("second flag register low bits not zero");
   flags_three_zero_a: assert property (rd_ack && wb_adr_i == 16'hfe06 |-> wb_dat_o[7:1] == 7'h00)
      else $error("third flag register upper bits not zero");
   // sp_o and stack_left_o trail the internal counters by one register stage
   sp_push_a: assert property (push_i && !pull_i |-> ##2 sp_o == $past(sp_o) - 16'h0001)
      else $error("push did not decrement the stack pointer");
   sp_pull_a: assert property (pull_i && !push_i |-> ##2 sp_o == $past(sp_o) + 16'h0001)
      else $error("pull did not increment the stack pointer");
   entry_depth_a: assert property (irq_entry_i |-> ##2 stack_left_o == 3'h5)
      else $error("interrupt entry did not load five bytes");
   call_depth_a: assert property (call_i |-> ##2 stack_left_o == 3'h2)
      else $error("call did not load two bytes");
   stack_count_a: assert property (push_i && stack_left_o != 3'h0 && !irq_entry_i && !call_i
      |-> ##2 stack_left_o == $past(stack_left_o, 2) - 3'h1)
      else $error("push did not count down the bytes left");
   ram_decode_a: assert property (1'b1 |=> ram_hit_o ==
      ($past(fetch_adr_i) >= 16'h0080 && $past(fetch_adr_i) <= 16'h00ff))
      else $error("ram decode wrong for fetch address");
endmodule // ivs_top_asserts
bind ivs_top ivs_top_asserts ivs_top_asserts_inst (.clk_i(clk_i), .rst_i(rst_i),
   .wb_adr_i(wb_adr_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .push_i(push_i), .pull_i(pull_i),
   .irq_entry_i(irq_entry_i), .call_i(call_i), .fetch_adr_i(fetch_adr_i), .sp_o(sp_o),
   .stack_left_o(stack_left_o), .ram_hit_o(ram_hit_o));

//--- testbench/ivs_core_model.sv
// processor core stand-in: trap, interrupt entry, calls, stack traffic, fetches
// assumes the bench calls one task at a time; strobes move on rising edges
module ivs_core_model (
   input wire clk_i, // clock
   input wire [7:0] fetch_dat_i, // fetched byte
   output logic software_trap_o = 1'b0, // trap pulse
   output logic irq_entry_o = 1'b0, // entry pulse
   output logic call_o = 1'b0, // call pulse
   output logic push_o = 1'b0, // push pulse
   output logic pull_o = 1'b0, // pull pulse
   output logic [15:0] fetch_adr_o = 16'hc000 // fetch address
);
   timeunit 1ns;
   timeprecision 1ns;
   // one-cycle strobe, then a quiet cycle so pulses never merge
   task automatic strobe(input int k);
      @(posedge clk_i);
      case (k)
         0: software_trap_o <= 1'b1;
         1: irq_entry_o <= 1'b1;
         2: call_o <= 1'b1;
         3: push_o <= 1'b1;
         default: pull_o <= 1'b1;
      endcase
      @(posedge clk_i);
      {software_trap_o, irq_entry_o, call_o, push_o, pull_o} <= 5'h00;
   endtask
   // five context bytes; index high is left out, so no sixth push
   task automatic enter_irq;
      strobe(1);
      repeat (5) strobe(3);
   endtask
   // two return bytes; callers keep the stack inside 0080..00ff
   task automatic enter_call;
      strobe(2);
      repeat (2) strobe(3);
   endtask
   task automatic unstack(input int n);
      repeat (n) strobe(4);
   endtask
   // byte comes back one edge later; taken at the falling edge, settled
   task automatic fetch(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk_i);
      fetch_adr_o <= a;
      @(posedge clk_i);
      @(negedge clk_i);
      d = fetch_dat_i;
   endtask
endmodule // ivs_core_model

//--- testbench/ivs_top_bench.sv
// self-checking bench for ivs_top: registers, vectors, stacking, interrupt line
// assumes ivs_core_model drives the core strobes and the checker is bound
module ivs_top_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [15:0] wb_adr_i = 16'h0000;
   logic [31:0] wb_dat_i = 32'h0000_0000;
   logic wb_we_i = 1'b0;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic [5:0] src = 6'h00;
   logic [31:0] wb_dat_o, q;
   logic wb_ack_o, irq_pending_o, ram_hit_o, irq_o, trap, entry, call, push, pull;
   logic [15:0] fetch_adr_i, vector_o, sp_o;
   logic [7:0] fetch_dat_o, b;
   logic [2:0] stack_left_o;
   // vector of each source pin, then the trap, lowest priority first
   logic [15:0] vt [7] = '{16'hffde, 16'hffe0, 16'hfff2, 16'hfff4, 16'hfff6, 16'hfffa, 16'hfffc};
   int fail_count = 0;
   int n_compared = 0;
   always #50 clk_i = ~clk_i;
   ivs_top ivs_top_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_adr_i(wb_adr_i),
      .wb_dat_i(wb_dat_i), .wb_sel_i(4'hf), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .conversion_done_i(src[0]), .keypad_i(src[1]), .timer_overflow_i(src[2]),
      .timer_ch1_i(src[3]), .timer_ch0_i(src[4]), .ext_request_i(src[5]),
      .software_trap_i(trap), .irq_entry_i(entry), .call_i(call), .push_i(push),
      .pull_i(pull), .fetch_adr_i(fetch_adr_i), .fetch_dat_o(fetch_dat_o),
      .vector_o(vector_o), .irq_pending_o(irq_pending_o), .sp_o(sp_o),
      .stack_left_o(stack_left_o), .ram_hit_o(ram_hit_o), .irq_o(irq_o));
   ivs_core_model ivs_core_model_inst (.clk_i(clk_i), .fetch_dat_i(fetch_dat_o),
      .software_trap_o(trap), .irq_entry_o(entry), .call_o(call), .push_o(push),
      .pull_o(pull), .fetch_adr_o(fetch_adr_i));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   // classic single cycle; a slave that never answers counts as a mismatch
   task automatic bus(input logic [15:0] a, input logic w, input logic [31:0] d);
      int n = 0;
      @(posedge clk_i);
      {wb_adr_i, wb_we_i, wb_dat_i, wb_cyc_i, wb_stb_i} <= {a, w, d, 2'h3};
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1 && n < 20) begin
         n++;
         @(posedge clk_i);
      end
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
      if (n == 20) chk(32'h0, 32'h1);
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] exp);
      bus(a, 1'b0, 32'h0000_0000);
      chk(q, exp);
   endtask
   // wait, bounded, for vector_o (sel 0) or irq_o (sel 1) to settle
   task automatic wait_on(input int sel, input logic [15:0] exp);
      logic [15:0] s;
      for (int n = 0; n < 20; n++) begin
         @(negedge clk_i);
         s = sel ? {15'h0000, irq_o} : vector_o;
         if (s === exp) break;
      end
      chk(s, exp);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset;
      rd(16'hfe04, 32'h0);
      rd(16'hfe05, 32'h0);
      rd(16'hfe06, 32'h0);
      rd(16'hfe11, 32'h0);
      bus(16'hfe04, 1'b1, 32'h0000_00ff);
      rd(16'hfe04, 32'h0);
      rd(16'h1000, 32'h0);
      rd(16'h0090, 32'h1);
      chk(sp_o, 16'h00ff);
      chk(vector_o, 16'hfffe);
      foreach (vt[i]) chk(irq_o, 1'b0);
   endtask
   // table bytes, then sources raised in rising priority; each must win
   task automatic t_vectors;
      foreach (vt[i]) bus(vt[i], 1'b1, {16'h0000, 8'ha0 + 8'(i), 8'h30 + 8'(i)});
      foreach (vt[i]) begin
         ivs_core_model_inst.fetch(vt[i], b);
         chk(b, 8'ha0 + 8'(i));
         ivs_core_model_inst.fetch(vt[i] + 16'h0001, b);
         chk(b, 8'h30 + 8'(i));
      end
      bus(16'hfe11, 1'b1, 32'h0000_00ff);
      for (int i = 0; i < 6; i++) begin
         src[i] <= 1'b1;
         wait_on(0, vt[i]);
      end
      ivs_core_model_inst.strobe(0);
      wait_on(0, 16'hfffc);
      chk(irq_pending_o, 1'b1);
      rd(16'hfe04, 32'h74);
      rd(16'hfe05, 32'h0);
      rd(16'hfe06, 32'h1);
   endtask
   // entry takes the trap, the rest stays pending; stack moves by 5 and 2
   task automatic t_stack;
      ivs_core_model_inst.enter_irq;
      repeat (2) @(negedge clk_i); // sp_o is one stage behind the pointer
      chk(sp_o, 16'h00fa);
      chk(stack_left_o, 3'h0);
      wait_on(0, 16'hfffa);
      ivs_core_model_inst.enter_call;
      repeat (2) @(negedge clk_i);
      chk(sp_o, 16'h00f8);
      ivs_core_model_inst.unstack(7);
      repeat (2) @(negedge clk_i);
      chk(sp_o, 16'h00ff);
      foreach (vt[i]) ivs_core_model_inst.fetch(16'h007f + 16'(i * 64), b);
   endtask
   // sticky status, mask gating, write-one clear
   task automatic t_irq;
      src <= 6'h00;
      bus(16'hfe11, 1'b1, 32'h0000_0000);
      wait_on(1, 16'h0000);
      rd(16'hfe04, 32'h0);
      rd(16'hfe10, 32'h0000_00fc);
      bus(16'hfe11, 1'b1, 32'h0000_00ff);
      wait_on(1, 16'h0001);
      bus(16'hfe10, 1'b1, 32'h0000_00ff);
      wait_on(1, 16'h0000);
      wait_on(0, 16'hfffe);
   endtask
   task automatic give_verdict;
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset;
      t_vectors;
      t_stack;
      t_irq;
      give_verdict;
   end
   // the whole run needs well under 2000 cycles
   initial begin
      #1_000_000;
      fail_count++;
      give_verdict;
   end
endmodule // ivs_top_bench
